/* logic/tsf_defines.svh */
// Register map, field positions and format codes of the slot control block
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH

`define TSF_CTRL_ADDR 8'h11
`define TSF_CTRL_RESET 16'h0000
`define TSF_FIRST_EN_BIT 0
`define TSF_FIRST_FMT_HI 4
`define TSF_FIRST_FMT_LO 2
`define TSF_SECOND_EN_BIT 5
`define TSF_SECOND_FMT_HI 8
`define TSF_SECOND_FMT_LO 6

`define TSF_FMT_NONE 3'h0
`define TSF_FMT_SUM16 3'h1
`define TSF_FMT_SUM32 3'h2
`define TSF_FMT_CHAN16 3'h4
`define TSF_FMT_CHAN32 3'h6

`define TSF_WORDS_SUM16 4'h1
`define TSF_WORDS_SUM32 4'h2
`define TSF_WORDS_CHAN16 4'h4
`define TSF_WORDS_CHAN32 4'h8

`endif

/* logic/tsf_pkg.sv */
// Types shared by the slot control block
package tsf_pkg;
  typedef enum logic {TSF_IDLE, TSF_EMIT} tsf_state_t;
  typedef enum logic {TSF_SLOT_FIRST, TSF_SLOT_SECOND} tsf_slot_t;
endpackage : tsf_pkg

/* logic/tsf_fifo.sv */
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tsf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap freely, so only power-of-two depths keep them in step
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : paramCheck
    $error("tsf_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      wrPtr_d = wrPtr_q + 1'b1;
    end
    if (pop) begin
      rdPtr_d = rdPtr_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Storage has no reset; only entries below count are ever presented
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule : tsf_fifo
`default_nettype wire

/* logic/tsf_slot_control.sv */
// Slot enable and FIFO output format control with result packing
//
// How it works
// - First slot runs only while control bit 0 is one.
// - Second slot runs only while control bit 5 is one.
// - Bits 4:2 pick first slot format; zero writes nothing; others reserved.
// - Code 1 writes 16-bit four-channel sum; code 2 writes it 32-bit.
// - Code 4 writes four 16-bit channel words; code 6 four 32-bit words.
// - Second slot results go to FIFO only while bit 5 is one, in its chosen nonzero, non-reserved format.
// - Bits 8:6 pick second slot format with the same code meanings.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_defines.svh"
module tsf_slot_control #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  input wire logic sampleTick,
  output logic firstSlotStart,
  output logic secondSlotStart,
  output logic first_slot_enable,
  output logic second_slot_enable,
  input wire logic resultValid,
  input wire tsf_pkg::tsf_slot_t resultSlot,
  input wire logic [31:0] chan0,
  input wire logic [31:0] chan1,
  input wire logic [31:0] chan2,
  input wire logic [31:0] chan3,
  output logic resultReady,
  output logic fifoOutValid,
  input wire logic fifoOutReady,
  output logic [15:0] fifoOutData
);
  import tsf_pkg::*;

  localparam int WORD_W = 16;

  // Below two entries the packer could never run ahead of the reader
  if (FIFO_DEPTH < 2) begin : depthCheck
    $error("tsf_slot_control: FIFO_DEPTH too small");
  end

  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] rdData_q, rdData_d;
  logic firstStart_q, firstStart_d, secondStart_q, secondStart_d;
  tsf_state_t state_q, state_d;
  logic [2:0] fmt_q, fmt_d;
  logic [3:0] wordIdx_q, wordIdx_d;
  logic [3:0] wordCnt_q, wordCnt_d;
  logic [31:0] ch_q [4];
  logic [31:0] ch_d [4];
  logic [31:0] sum_q, sum_d;

  logic [2:0] firstFmt, secondFmt, selFmt;
  logic selEnable;
  logic [3:0] selCount;
  logic [15:0] word;
  logic wordValid, wordReady;
  logic [31:0] chSel;

  assign first_slot_enable = ctrl_q[`TSF_FIRST_EN_BIT];
  assign second_slot_enable = ctrl_q[`TSF_SECOND_EN_BIT];
  assign firstFmt = ctrl_q[`TSF_FIRST_FMT_HI:`TSF_FIRST_FMT_LO];
  assign secondFmt = ctrl_q[`TSF_SECOND_FMT_HI:`TSF_SECOND_FMT_LO];
  assign regRdData = rdData_q;
  assign firstSlotStart = firstStart_q;
  assign secondSlotStart = secondStart_q;
  // Dropped results are taken at once, so only a packing burst stalls
  assign resultReady = (state_q == TSF_IDLE);

  // Format and enable of the slot whose result is offered
  always_comb begin
    if (resultSlot == TSF_SLOT_FIRST) begin
      selFmt = firstFmt;
      selEnable = first_slot_enable;
    end else begin
      // Host keeps averaging equal or first format zero here
      selFmt = secondFmt;
      selEnable = second_slot_enable;
    end
    case (selFmt)
      `TSF_FMT_SUM16: selCount = `TSF_WORDS_SUM16;
      `TSF_FMT_SUM32: selCount = `TSF_WORDS_SUM32;
      `TSF_FMT_CHAN16: selCount = `TSF_WORDS_CHAN16;
      `TSF_FMT_CHAN32: selCount = `TSF_WORDS_CHAN32;
      // Code zero and reserved codes write nothing
      default: selCount = 4'h0;
    endcase
  end

  // Word currently presented to the FIFO; 32-bit values go high half first
  always_comb begin
    chSel = ch_q[0];
    word = '0;
    case (fmt_q)
      `TSF_FMT_SUM16: word = sum_q[15:0];
      `TSF_FMT_SUM32: word = wordIdx_q[0] ? sum_q[15:0] : sum_q[31:16];
      `TSF_FMT_CHAN16: begin
        chSel = ch_q[wordIdx_q[1:0]];
        word = chSel[15:0];
      end
      `TSF_FMT_CHAN32: begin
        chSel = ch_q[wordIdx_q[2:1]];
        word = wordIdx_q[0] ? chSel[15:0] : chSel[31:16];
      end
      default: word = '0;
    endcase
  end

  assign wordValid = (state_q == TSF_EMIT);

  always_comb begin
    ctrl_d = ctrl_q;
    rdData_d = rdData_q;
    firstStart_d = 1'b0;
    secondStart_d = 1'b0;
    state_d = state_q;
    fmt_d = fmt_q;
    wordIdx_d = wordIdx_q;
    wordCnt_d = wordCnt_q;
    sum_d = sum_q;
    for (int i = 0; i < 4; i++) begin
      ch_d[i] = ch_q[i];
    end
    if (regWrEn && regAddr == `TSF_CTRL_ADDR) begin
      // Reserved bits are not stored and read back as zero
      ctrl_d = 16'h0000;
      ctrl_d[`TSF_FIRST_EN_BIT] = regWrData[`TSF_FIRST_EN_BIT];
      ctrl_d[`TSF_SECOND_EN_BIT] = regWrData[`TSF_SECOND_EN_BIT];
      ctrl_d[`TSF_FIRST_FMT_HI:`TSF_FIRST_FMT_LO] =
        regWrData[`TSF_FIRST_FMT_HI:`TSF_FIRST_FMT_LO];
      ctrl_d[`TSF_SECOND_FMT_HI:`TSF_SECOND_FMT_LO] =
        regWrData[`TSF_SECOND_FMT_HI:`TSF_SECOND_FMT_LO];
    end
    // Registered read: data for an address shows one cycle after it
    rdData_d = (regAddr == `TSF_CTRL_ADDR) ? ctrl_q : 16'h0000;
    // Starts follow the enable bits as they stand when the tick arrives
    if (sampleTick) begin
      firstStart_d = first_slot_enable;
      secondStart_d = second_slot_enable;
    end
    case (state_q)
      TSF_IDLE: begin
        if (resultValid && selEnable && selCount != 4'h0) begin
          state_d = TSF_EMIT;
          fmt_d = selFmt;
          wordCnt_d = selCount;
          wordIdx_d = 4'h0;
          ch_d[0] = chan0;
          ch_d[1] = chan1;
          ch_d[2] = chan2;
          ch_d[3] = chan3;
          // Sum wraps at 32 bits; the 16-bit form keeps the low half
          sum_d = chan0 + chan1 + chan2 + chan3;
        end
      end
      TSF_EMIT: begin
        if (wordReady) begin
          wordIdx_d = wordIdx_q + 4'h1;
          if (wordIdx_q + 4'h1 == wordCnt_q) begin
            state_d = TSF_IDLE;
          end
        end
      end
      default: state_d = TSF_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `TSF_CTRL_RESET;
      rdData_q <= 16'h0000;
      firstStart_q <= 1'b0;
      secondStart_q <= 1'b0;
      state_q <= TSF_IDLE;
      fmt_q <= `TSF_FMT_NONE;
      wordIdx_q <= 4'h0;
      wordCnt_q <= 4'h0;
      sum_q <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        ch_q[i] <= 32'h0000_0000;
      end
    end else begin
      ctrl_q <= ctrl_d;
      rdData_q <= rdData_d;
      firstStart_q <= firstStart_d;
      secondStart_q <= secondStart_d;
      state_q <= state_d;
      fmt_q <= fmt_d;
      wordIdx_q <= wordIdx_d;
      wordCnt_q <= wordCnt_d;
      sum_q <= sum_d;
      for (int i = 0; i < 4; i++) begin
        ch_q[i] <= ch_d[i];
      end
    end
  end

  // A full FIFO stalls the packer and so the result source
  tsf_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) tsf_fifo_inst (
    .clk(clk),
    .reset(reset),
    .inValid(wordValid),
    .inReady(wordReady),
    .inData(word),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );
endmodule : tsf_slot_control
`default_nettype wire

/* tb/tsf_slot_checker.sv */
// Port assertions for slot control
`timescale 1ns/1ps
`default_nettype none
module tsf_slot_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic sampleTick,
  input wire logic firstSlotStart,
  input wire logic secondSlotStart,
  input wire logic first_slot_enable,
  input wire logic second_slot_enable,
  input wire logic resultValid,
  input wire tsf_pkg::tsf_slot_t resultSlot,
  input wire logic resultReady
);
  import tsf_pkg::*;
  logic take;
  logic ctl;
  assign take = resultValid && resultReady;
  assign ctl = regAddr == 8'h11;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_first_run: assert property (sampleTick |=>
    firstSlotStart == $past(first_slot_enable)) else $error("first start");
  chk_second_run: assert property (sampleTick |=>
    secondSlotStart == $past(second_slot_enable)) else $error("second start");
  chk_en_write: assert property (regWrEn && ctl |=>
    {second_slot_enable, first_slot_enable} == $past({regWrData[5],
    regWrData[0]})) else $error("enable write");
  chk_en_hold: assert property (!regWrEn |=> $stable(first_slot_enable)
    && $stable(second_slot_enable)) else $error("enable moved");
  // Reserved bits are masked off, so only the fields come back
  chk_field_store: assert property (regWrEn && ctl ##1 !regWrEn && ctl
    |=> regRdData == ($past(regWrData, 2) & 16'h01FD)) else $error("store");
  chk_res_zero: assert property (ctl |=>
    (regRdData & 16'hFE02) == 16'h0000) else $error("reserved bits");
  chk_first_drop: assert property (take && resultSlot == TSF_SLOT_FIRST
    && !first_slot_enable |=> resultReady) else $error("first drop");
  chk_second_drop: assert property (take && resultSlot == TSF_SLOT_SECOND
    && !second_slot_enable |=> resultReady) else $error("second drop");
  cov_take: cover property (take);
  cov_both: cover property (firstSlotStart && secondSlotStart);
  cov_store: cover property (regWrEn && ctl ##1 !regWrEn && ctl);
endmodule : tsf_slot_checker
bind tsf_slot_control tsf_slot_checker tsf_slot_checker_inst (.clk, .reset,
  .regAddr, .regWrEn, .regWrData, .regRdData, .sampleTick, .firstSlotStart,
  .secondSlotStart, .first_slot_enable, .second_slot_enable, .resultValid,
  .resultSlot, .resultReady);
`default_nettype wire

/* tb/tsf_reader_model.sv */
// Output word reader that can stall
`timescale 1ns/1ps
`default_nettype none
module tsf_reader_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic valid,
  input wire logic [15:0] data,
  output logic ready
);
  logic [15:0] got[$];
  assign ready = !stall;
  always @(posedge clk) begin
    if (valid && ready) got.push_back(data);
  end
endmodule : tsf_reader_model
`default_nettype wire

/* tb/tsf_slot_control_bench.sv */
// Self-checking bench for slot control
`timescale 1ns/1ps
`default_nettype none
module tsf_slot_control_bench;
  import tsf_pkg::*;
  logic clk = 0, reset = 1, regWrEn = 0, sampleTick = 0, resultValid = 0;
  logic stall = 0, fifoOutReady, fifoOutValid, resultReady, firstSlotStart;
  logic secondSlotStart, first_slot_enable, second_slot_enable;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000, regRdData, fifoOutData, d;
  logic [31:0] chan0 = 32'h1234_5678, chan1 = 32'hF000_8001;
  logic [31:0] chan2 = 32'hA5A5_0F0F, chan3 = 32'h0000_0101;
  tsf_slot_t resultSlot = TSF_SLOT_FIRST;
  int num_errors = 0, check_count = 0, cycles = 0;
  logic [15:0] enables, starts;
  assign enables = {14'h0000, second_slot_enable, first_slot_enable};
  assign starts = {14'h0000, secondSlotStart, firstSlotStart};
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  tsf_slot_control #(.FIFO_DEPTH(8)) tsf_slot_control_inst (.clk, .reset,
    .regAddr, .regWrEn, .regWrData, .regRdData, .sampleTick, .firstSlotStart,
    .secondSlotStart, .first_slot_enable, .second_slot_enable, .resultValid,
    .resultSlot, .chan0, .chan1, .chan2, .chan3, .resultReady, .fifoOutValid,
    .fifoOutReady, .fifoOutData);
  tsf_reader_model tsf_reader_model_inst (.clk, .stall,
    .valid(fifoOutValid), .data(fifoOutData), .ready(fifoOutReady));
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(negedge clk);
    regAddr = a;
    regWrEn = 1;
    regWrData = v;
    @(negedge clk);
    regWrEn = 0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    d = regRdData;
  endtask : rd
  function automatic logic [15:0] ew(logic [2:0] code, int i);
    logic [31:0] c[4] = '{chan0, chan1, chan2, chan3};
    logic [31:0] s = chan0 + chan1 + chan2 + chan3;
    if (code == 3'h1) return s[15:0];
    if (code == 3'h2) return i ? s[15:0] : s[31:16];
    if (code == 3'h4) return c[i][15:0];
    return i[0] ? c[i/2][15:0] : c[i/2][31:16];
  endfunction : ew
  // Tick first, then offer only when idle so one result is taken once
  task automatic offer(tsf_slot_t s);
    @(negedge clk);
    sampleTick = 1;
    @(negedge clk);
    sampleTick = 0;
    while (resultReady !== 1'b1) @(negedge clk);
    resultValid = 1;
    resultSlot = s;
    @(negedge clk);
    resultValid = 0;
  endtask : offer
  // Start pulses stand for one cycle, so look at the negedge right after
  task automatic tick_check(logic [1:0] exp);
    @(negedge clk);
    sampleTick = 1;
    @(negedge clk);
    sampleTick = 0;
    check("starts", 16'(exp), starts);
  endtask : tick_check
  task automatic expect_words(string what, logic [2:0] code, int reps);
    int n;
    n = code == 3'h6 ? 8 : code inside {3'h1, 3'h2, 3'h4} ? code : 0;
    repeat (30) @(negedge clk);
    check(what, 16'(n * reps), 16'(tsf_reader_model_inst.got.size()));
    foreach (tsf_reader_model_inst.got[i])
      check(what, ew(code, i % n), tsf_reader_model_inst.got[i]);
    tsf_reader_model_inst.got.delete();
  endtask : expect_words
  task automatic test_regs;
    rd(8'h11);
    check("ctrl reset", 16'h0000, d);
    wr(8'h11, 16'hFFFF);
    check("enables", 16'h0003, enables);
    tick_check(2'b11);
    rd(8'h11);
    check("ctrl mask", 16'h01FD, d);
    rd(8'h12);
    check("unmapped", 16'h0000, d);
    $display("regs done");
  endtask : test_regs
  task automatic test_formats;
    logic [2:0] codes[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    foreach (codes[k]) begin
      // Equal averaging assumed
      wr(8'h11, {7'h00, codes[k], 1'b1, codes[k], 2'b01});
      offer(TSF_SLOT_FIRST);
      expect_words("first", codes[k], 1);
      offer(TSF_SLOT_SECOND);
      expect_words("second", codes[k], 1);
    end
    wr(8'h11, 16'h0044);
    tick_check(2'b00);
    offer(TSF_SLOT_FIRST);
    offer(TSF_SLOT_SECOND);
    expect_words("disabled", 3'h0, 1);
    $display("formats done");
  endtask : test_formats
  task automatic test_full;
    stall = 1;
    wr(8'h11, 16'h0019);
    offer(TSF_SLOT_FIRST);
    offer(TSF_SLOT_FIRST);
    repeat (12) @(negedge clk);
    check("stalled", 16'h0000, 16'(resultReady));
    stall = 0;
    expect_words("drain", 3'h6, 2);
    check("empty", 16'h0000, 16'(fifoOutValid));
    $display("full done");
  endtask : test_full
  task automatic test_reset;
    wr(8'h11, 16'h0021);
    check("enables set", 16'h0003, enables);
    tick_check(2'b11);
    @(negedge clk);
    reset = 1;
    repeat (2) @(negedge clk);
    reset = 0;
    check("enables reset", 16'h0000, enables);
    rd(8'h11);
    check("ctrl after reset", 16'h0000, d);
    $display("reset done");
  endtask : test_reset
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (16) @(negedge clk);
    reset = 0;
    test_regs();
    test_formats();
    test_full();
    test_reset();
    wrap_up();
  end
endmodule : tsf_slot_control_bench
`default_nettype wire
